/* File: src/arb_pkg.sv */
// Shared constants, types and helper functions of the CPU register bridge.
package arb_pkg;

  // ****************************************************************
  // Widths of the CPU bus and of the local register interface
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BADDR_W = 15;
  localparam int WADDR_W = 13;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // ****************************************************************
  // Byte offsets of the network register areas
  // ****************************************************************
  localparam logic [BADDR_W-1:0] OFS_CORE_LAST = 15'h00ff;
  localparam logic [BADDR_W-1:0] OFS_CORE_RESET = 15'h0000;
  localparam logic [BADDR_W-1:0] OFS_CORE_CMD = 15'h0004;
  localparam logic [BADDR_W-1:0] OFS_PAYLOAD = 15'h1000;
  localparam logic [BADDR_W-1:0] OFS_TXMAC = 15'h2000;
  localparam logic [BADDR_W-1:0] OFS_TXBUF = 15'h3000;
  localparam logic [BADDR_W-1:0] OFS_RXBUF = 15'h4000;
  localparam logic [BADDR_W-1:0] OFS_RXMAC = 15'h5000;
  localparam logic [BADDR_W-1:0] OFS_STAT = 15'h6000;
  // Field of the byte offset that selects a 4 KB area.
  localparam int AREA_MSB = 14;
  localparam int AREA_LSB = 12;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_CORE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CORE_CMD = 32'h0000_0000;
  localparam int READ_LAT = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    AREA_CORE, AREA_PAYLOAD, AREA_TXMAC, AREA_TXBUF,
    AREA_RXBUF, AREA_RXMAC, AREA_STAT, AREA_NONE
  } arb_area_t;

  typedef struct packed {
    logic wr;
    logic [WADDR_W-1:0] waddr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
  } arb_lreq_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
  } arb_lwr_t;

  typedef struct packed {
    logic core;
    logic payload;
    logic txmac;
    logic txbuf;
    logic rxmac;
  } arb_area_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] core;
    logic [DATA_W-1:0] txmac;
    logic [DATA_W-1:0] rxbuf;
    logic [DATA_W-1:0] rxmac;
    logic [DATA_W-1:0] stat;
  } arb_rd_src_t;

  // Area that a word address falls into; gaps decode to AREA_NONE.
  function automatic arb_area_t arb_area(input logic [WADDR_W-1:0] waddr);
    logic [BADDR_W-1:0] b;
    logic [2:0] f;
    b = {waddr, 2'h0};
    f = b[AREA_MSB:AREA_LSB];
    if (b <= OFS_CORE_LAST) return AREA_CORE;
    if (b == OFS_PAYLOAD) return AREA_PAYLOAD;
    if (f == OFS_TXMAC[AREA_MSB:AREA_LSB]) return AREA_TXMAC;
    if (f == OFS_TXBUF[AREA_MSB:AREA_LSB]) return AREA_TXBUF;
    if (f == OFS_RXBUF[AREA_MSB:AREA_LSB]) return AREA_RXBUF;
    if (f == OFS_RXMAC[AREA_MSB:AREA_LSB]) return AREA_RXMAC;
    if (f == OFS_STAT[AREA_MSB:AREA_LSB]) return AREA_STAT;
    return AREA_NONE;
  endfunction : arb_area

  // Byte-lane merge of a write into a stored word.
  function automatic logic [DATA_W-1:0] arb_merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction : arb_merge

endpackage : arb_pkg

/* File: src/arb_network_register_decoder.sv */
// Network-clock register decoder with a fixed three-cycle read latency.
`timescale 1ns/1ps
`default_nettype none
module arb_network_register_decoder (
  // Network clock and its synchronised reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Local register interface from the bridge
  input wire logic i_wr_en,
  input wire logic i_rd_req,
  input wire logic [arb_pkg::WADDR_W-1:0] i_laddr,
  input wire arb_pkg::arb_lwr_t i_lwr,
  output logic o_rd_valid,
  output logic [arb_pkg::DATA_W-1:0] o_rd_word,
  // Area side
  output var arb_pkg::arb_area_wr_t o_area_wr,
  output logic [arb_pkg::WADDR_W-1:0] o_laddr,
  output var arb_pkg::arb_lwr_t o_lwr,
  output logic [arb_pkg::DATA_W-1:0] o_core_reset,
  output logic [arb_pkg::DATA_W-1:0] o_core_cmd,
  input wire arb_pkg::arb_rd_src_t i_rd_src
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  arb_pkg::arb_area_t area;
  arb_pkg::arb_area_t area1_r;
  arb_pkg::arb_area_wr_t area_wr_nxt;
  logic [arb_pkg::BADDR_W-1:0] bofs;
  logic hit_reset;
  logic hit_cmd;
  logic int1_r;
  logic [arb_pkg::READ_LAT-1:0] rq_r;
  logic [arb_pkg::DATA_W-1:0] core1_r;
  logic [arb_pkg::DATA_W-1:0] mux2_r;
  logic [arb_pkg::DATA_W-1:0] mux2_nxt;

  // The upper offset bits pick the target; read-only areas get no strobe.
  assign area = arb_pkg::arb_area(i_laddr);
  assign bofs = {i_laddr, 2'h0};
  assign hit_reset = (area == arb_pkg::AREA_CORE) &&
                     (bofs == arb_pkg::OFS_CORE_RESET);
  assign hit_cmd = (area == arb_pkg::AREA_CORE) &&
                   (bofs == arb_pkg::OFS_CORE_CMD);
  assign area_wr_nxt.core = i_wr_en && (area == arb_pkg::AREA_CORE);
  assign area_wr_nxt.payload = i_wr_en &&
                               (area == arb_pkg::AREA_PAYLOAD);
  assign area_wr_nxt.txmac = i_wr_en && (area == arb_pkg::AREA_TXMAC);
  assign area_wr_nxt.txbuf = i_wr_en && (area == arb_pkg::AREA_TXBUF);
  assign area_wr_nxt.rxmac = i_wr_en && (area == arb_pkg::AREA_RXMAC);

  // Strobes, address and data leave together so areas see one RAM port.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_area_wr <= '0;
      o_laddr <= '0;
      o_lwr <= '0;
      o_core_reset <= arb_pkg::RST_CORE_RESET;
      o_core_cmd <= arb_pkg::RST_CORE_CMD;
    end else begin
      o_area_wr <= area_wr_nxt;
      o_laddr <= i_laddr;
      o_lwr <= i_lwr;
      if (i_wr_en && hit_reset) begin
        o_core_reset <= arb_pkg::arb_merge(o_core_reset, i_lwr.data, i_lwr.be);
      end
      if (i_wr_en && hit_cmd) begin
        o_core_cmd <= arb_pkg::arb_merge(o_core_cmd, i_lwr.data, i_lwr.be);
      end
    end
  end

  // ****************************************************************
  // Three-stage read multiplexer
  // ****************************************************************
  // Stage two samples area words one cycle after o_laddr settles.
  assign mux2_nxt =
    (area1_r == arb_pkg::AREA_CORE) ? (int1_r ? core1_r : i_rd_src.core) :
    (area1_r == arb_pkg::AREA_TXMAC) ? i_rd_src.txmac :
    (area1_r == arb_pkg::AREA_RXBUF) ? i_rd_src.rxbuf :
    (area1_r == arb_pkg::AREA_RXMAC) ? i_rd_src.rxmac :
    (area1_r == arb_pkg::AREA_STAT) ? i_rd_src.stat : '0;

  // Valid is the request delayed by exactly three flip-flops.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rq_r <= '0;
      area1_r <= arb_pkg::AREA_NONE;
      int1_r <= 1'b0;
      core1_r <= '0;
      mux2_r <= '0;
      o_rd_word <= '0;
    end else begin
      rq_r <= {rq_r[arb_pkg::READ_LAT-2:0], i_rd_req};
      area1_r <= area;
      int1_r <= hit_reset || hit_cmd;
      core1_r <= hit_reset ? o_core_reset : o_core_cmd;
      mux2_r <= mux2_nxt;
      if (rq_r[arb_pkg::READ_LAT-2]) o_rd_word <= mux2_r;
    end
  end

  assign o_rd_valid = rq_r[arb_pkg::READ_LAT-1];

endmodule : arb_network_register_decoder
`default_nettype wire

/* File: src/arb_cpu_register_access_top.sv */
// AXI4-Lite slave that bridges CPU accesses into the network clock domain.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// CPU register access top
// ****************************************************************
// Summary of operation
// - Offer a 32-bit AXI4-Lite slave taking both writes and reads.
// - One bridge per local clock; this one serves the network clock.
// - Write address, write data, read address, read data run apart.
// - Captured write address and data cross over to the local write.
// - Local read data crosses back before reaching the read channel.
// - One local address bus, loaded from write or read address.
// - Never a local write and a local read in the same cycle.
// - Write strobe pulses with word address, data and byte enables.
// - Four byte enables, bit n marking data byte n.
// - Read request rises together with a valid address.
// - Address stays unchanged until read valid is seen.
// - Slave returns data with read valid; bridge forwards that word.
// - Offsets 0x0000 to 0x00FF reach the offload core registers.
// - A write to 0x1000 feeds a payload word to the offload core.
// - Offsets 0x2000 to 0x2FFF reach the transmit MAC controls.
// - Offsets 0x3000 to 0x3FFF write the transmit buffer only.
// - Offsets 0x4000 to 0x4FFF read the receive buffer only.
// - 0x5000 area is receive MAC; 0x6000 area reads core status.
// - Upper address bits pick the target; three read mux stages.
// - Read latency is three cycles, valid is request through three flops.
module arb_cpu_register_access_top (
  // CPU clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // AXI4-Lite write address channel
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [arb_pkg::BADDR_W-1:0] i_s_axi_awaddr,
  // AXI4-Lite write data channel
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [arb_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic [arb_pkg::BE_W-1:0] i_s_axi_wstrb,
  // AXI4-Lite write response channel
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read address channel
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [arb_pkg::BADDR_W-1:0] i_s_axi_araddr,
  // AXI4-Lite read data channel
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [arb_pkg::DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Network clock
  input wire logic i_net_clk,
  // Network areas, all on the network clock
  output var arb_pkg::arb_area_wr_t o_area_wr,
  output logic [arb_pkg::WADDR_W-1:0] o_laddr,
  output var arb_pkg::arb_lwr_t o_lwr,
  output logic [arb_pkg::DATA_W-1:0] o_core_reset,
  output logic [arb_pkg::DATA_W-1:0] o_core_cmd,
  input wire arb_pkg::arb_rd_src_t i_rd_src
);

  // ****************************************************************
  // CPU clock domain
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_RESP} arb_sys_state_t;

  // State of the one operation in flight.
  arb_sys_state_t st_r;
  arb_sys_state_t st_nxt;
  // Readies; low while a beat waits.
  logic awrdy_r;
  logic wrdy_r;
  logic ardy_r;
  // Captured beats.
  logic [arb_pkg::WADDR_W-1:0] aw_waddr_r;
  logic [arb_pkg::WADDR_W-1:0] ar_waddr_r;
  logic [arb_pkg::DATA_W-1:0] w_data_r;
  logic [arb_pkg::BE_W-1:0] w_be_r;
  // Last grant, for alternating.
  logic last_wr_r;
  // Responses shown to the CPU.
  logic bvalid_r;
  logic rvalid_r;
  logic [arb_pkg::DATA_W-1:0] rdata_r;
  // Request word and its toggle.
  arb_pkg::arb_lreq_t req_r;
  arb_pkg::arb_lreq_t req_nxt;
  logic req_tgl_r;
  // Acknowledge toggle synchroniser.
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_s3_r;

  // Handshake wires.
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic go_wr;
  logic go_rd;
  logic ack_edge;
  logic b_done;
  logic r_done;
  logic done_wr;
  logic done_rd;

  // ****************************************************************
  // Network clock domain signals
  // ****************************************************************
  typedef enum logic {LS_IDLE, LS_READ} arb_loc_state_t;

  // Local read state.
  arb_loc_state_t lst_r;
  arb_loc_state_t lst_nxt;
  // Network reset synchroniser.
  logic lrst_s1_r;
  logic lrst_s2_r;
  // Request toggle synchroniser.
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic req_edge;
  // Local strobes, address and word.
  logic lwr_r;
  logic lrd_req_r;
  logic [arb_pkg::WADDR_W-1:0] laddr_r;
  arb_pkg::arb_lwr_t lwr_word_r;
  // Acknowledge toggle, read word.
  logic ack_tgl_r;
  logic [arb_pkg::DATA_W-1:0] lrd_word_r;
  // Decoder answer.
  logic dec_rd_valid;
  logic [arb_pkg::DATA_W-1:0] dec_rd_word;
  logic rd_end;

  // ****************************************************************
  // AXI channel acceptance
  // ****************************************************************
  // Each channel owns its own ready, so address and data may come in
  // either order; a low ready means a captured beat is waiting.
  assign aw_take = i_s_axi_awvalid && awrdy_r;
  assign w_take = i_s_axi_wvalid && wrdy_r;
  assign ar_take = i_s_axi_arvalid && ardy_r;

  // Only one local operation is ever in flight, so the shared local
  // address can never carry a write and a read at once. Reads win when
  // the last grant went to a write, so neither side starves.
  assign go_wr = (st_r == ST_IDLE) && !awrdy_r && !wrdy_r &&
                 (ardy_r || !last_wr_r);
  assign go_rd = (st_r == ST_IDLE) && !ardy_r && !go_wr;

  // Request word for the network side, loaded by the winner.
  assign req_nxt.wr = go_wr;
  assign req_nxt.waddr = go_wr ? aw_waddr_r : ar_waddr_r;
  assign req_nxt.data = w_data_r;
  assign req_nxt.be = w_be_r;

  // Completion and response wires.
  assign ack_edge = ack_s2_r ^ ack_s3_r;
  assign done_wr = (st_r == ST_BUSY) && ack_edge && req_r.wr;
  assign done_rd = (st_r == ST_BUSY) && ack_edge && !req_r.wr;
  assign b_done = bvalid_r && i_s_axi_bready;
  assign r_done = rvalid_r && i_s_axi_rready;
  assign st_nxt = (go_wr || go_rd) ? ST_BUSY :
                  ack_edge && (st_r == ST_BUSY) ? ST_RESP :
                  (b_done || r_done) ? ST_IDLE : st_r;

  // Ready flags drop on capture and come back once the CPU has taken
  // the answer of that operation.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
      ardy_r <= 1'b1;
    end else begin
      if (aw_take) awrdy_r <= 1'b0;
      else if (b_done) awrdy_r <= 1'b1;
      if (w_take) wrdy_r <= 1'b0;
      else if (b_done) wrdy_r <= 1'b1;
      if (ar_take) ardy_r <= 1'b0;
      else if (r_done) ardy_r <= 1'b1;
    end
  end

  // Captured beats; the byte offset becomes a 32-bit word address.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      aw_waddr_r <= '0;
      ar_waddr_r <= '0;
      w_data_r <= '0;
      w_be_r <= '0;
    end else begin
      if (aw_take) aw_waddr_r <= i_s_axi_awaddr[arb_pkg::BADDR_W-1:2];
      if (ar_take) ar_waddr_r <= i_s_axi_araddr[arb_pkg::BADDR_W-1:2];
      if (w_take) w_data_r <= i_s_axi_wdata;
      if (w_take) w_be_r <= i_s_axi_wstrb;
    end
  end

  // ****************************************************************
  // Request launch and acknowledge crossing
  // ****************************************************************
  // The request word is held still from the toggle until the ack
  // returns, so the network side may read it after its two-stage
  // toggle synchroniser without any bit racing the strobe.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
      req_r <= '0;
      req_tgl_r <= 1'b0;
      last_wr_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      if (go_wr || go_rd) begin
        req_r <= req_nxt;
        req_tgl_r <= !req_tgl_r;
        last_wr_r <= go_wr;
      end
    end
  end

  // Responses stay up until the CPU takes them; every answer is OKAY,
  // including gaps in the map, which simply read as zero.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      if (done_wr) bvalid_r <= 1'b1;
      else if (b_done) bvalid_r <= 1'b0;
      if (done_rd) rvalid_r <= 1'b1;
      else if (r_done) rvalid_r <= 1'b0;
      if (done_rd) rdata_r <= lrd_word_r;
    end
  end

  assign o_s_axi_awready = awrdy_r;
  assign o_s_axi_wready = wrdy_r;
  assign o_s_axi_arready = ardy_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;

  // Constant OKAY still comes from flops so the ports stay registered.
  always_ff @(posedge i_sys_clk) begin
    o_s_axi_bresp <= arb_pkg::RESP_OKAY;
    o_s_axi_rresp <= arb_pkg::RESP_OKAY;
  end

  // ****************************************************************
  // Network clock domain
  // ****************************************************************
  // Reset is carried over by two flops; these carry no reset of their
  // own, so the network side leaves reset two edges after the CPU side.
  // A reset of only one side mid-operation is not supported.
  always_ff @(posedge i_net_clk) begin
    lrst_s1_r <= i_nrst;
    lrst_s2_r <= lrst_s1_r;
  end

  assign req_edge = req_s2_r ^ req_s3_r;
  assign rd_end = (lst_r == LS_READ) && dec_rd_valid;
  assign lst_nxt = (req_edge && !req_r.wr) ? LS_READ :
                   rd_end ? LS_IDLE : lst_r;

  // Toggle synchroniser for the request; only the edge is acted upon.
  always_ff @(posedge i_net_clk) begin
    if (!lrst_s2_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  // Local strobes: one-cycle write or read request with its address.
  // The address register is loaded only on a new request, so during a
  // read it stays put until the decoder reports read valid.
  always_ff @(posedge i_net_clk) begin
    if (!lrst_s2_r) begin
      lst_r <= LS_IDLE;
      lwr_r <= 1'b0;
      lrd_req_r <= 1'b0;
      laddr_r <= '0;
      lwr_word_r <= '0;
    end else begin
      lst_r <= lst_nxt;
      lwr_r <= req_edge && req_r.wr;
      lrd_req_r <= req_edge && !req_r.wr;
      if (req_edge) laddr_r <= req_r.waddr;
      if (req_edge) lwr_word_r <= {req_r.data, req_r.be};
    end
  end

  // Acknowledge toggles after the write strobe or when read data lands.
  always_ff @(posedge i_net_clk) begin
    if (!lrst_s2_r) begin
      ack_tgl_r <= 1'b0;
      lrd_word_r <= '0;
    end else begin
      if (lwr_r || rd_end) ack_tgl_r <= !ack_tgl_r;
      if (rd_end) lrd_word_r <= dec_rd_word;
    end
  end

  // ****************************************************************
  // Network register decoder
  // ****************************************************************
  // The decoder runs on the network clock.
  arb_network_register_decoder u_decoder (
    .i_clk(i_net_clk),
    .i_nrst(lrst_s2_r),
    .i_wr_en(lwr_r),
    .i_rd_req(lrd_req_r),
    .i_laddr(laddr_r),
    .i_lwr(lwr_word_r),
    .o_rd_valid(dec_rd_valid),
    .o_rd_word(dec_rd_word),
    .o_area_wr(o_area_wr),
    .o_laddr(o_laddr),
    .o_lwr(o_lwr),
    .o_core_reset(o_core_reset),
    .o_core_cmd(o_core_cmd),
    .i_rd_src(i_rd_src)
  );

endmodule : arb_cpu_register_access_top
`default_nettype wire

/* File: testbench/arb_bridge_chk.sv */
// Concurrent checks on the bridge handshakes and local write pulses.
`timescale 1ns/1ps
`default_nettype none
module arb_bridge_chk (
  // Clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_net_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_rready,
  input wire logic o_s_axi_awready,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic [arb_pkg::DATA_W-1:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire arb_pkg::arb_area_wr_t o_area_wr
);
  // ****************************************************************
  // CPU side handshakes
  // ****************************************************************
  a_bresp_okay: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_bvalid |-> o_s_axi_bresp == 2'h0) else $error("bresp not okay");
  a_bvalid_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid) else $error("bvalid drop");
  a_rresp_okay: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_rvalid |-> o_s_axi_rresp == 2'h0) else $error("rresp not okay");
  a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data moved");
  a_write_busy: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken early");
  a_read_busy: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken early");
  // Local strobes are single-cycle and hit one area only.
  a_wr_pulse: assert property (@(posedge i_net_clk) disable iff (!i_nrst)
    |o_area_wr |=> o_area_wr == '0) else $error("write strobe too long");
  a_one_area: assert property (@(posedge i_net_clk) disable iff (!i_nrst)
    $onehot0(o_area_wr)) else $error("two areas written");
endmodule : arb_bridge_chk
`default_nettype wire

/* File: testbench/arb_area_model.sv */
// Model of the network areas behind the bridge's local interface.
`timescale 1ns/1ps
`default_nettype none
module arb_area_model (
  // Network clock
  input wire logic i_net_clk,
  // Bridge area side
  input wire arb_pkg::arb_area_wr_t i_area_wr,
  input wire logic [12:0] i_laddr,
  input wire arb_pkg::arb_lwr_t i_lwr,
  output var arb_pkg::arb_rd_src_t o_rd_src,
  // Captured write traffic
  output logic [31:0] o_pay,
  output logic [31:0] o_txb,
  output logic [12:0] o_txb_addr
);
  logic [31:0] txm_r;
  logic [31:0] rxm_r;
  // Core, rxbuf and stat read words follow the address at once, so a stale address shows.
  assign o_rd_src.core = {16'hc0e0, 3'h0, i_laddr};
  assign o_rd_src.rxbuf = {16'hb0f0, 3'h0, i_laddr};
  assign o_rd_src.stat = {16'h5a7a, 3'h0, i_laddr};
  assign o_rd_src.txmac = txm_r;
  assign o_rd_src.rxmac = rxm_r;
  initial {txm_r, rxm_r, o_pay, o_txb, o_txb_addr} = '0;
  // In txm_r and rxm_r only enabled lanes change, so a wrong byte enable shows on read.
  always @(posedge i_net_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (i_area_wr.txmac && i_lwr.be[i]) txm_r[8*i +: 8] <= i_lwr.data[8*i +: 8];
      if (i_area_wr.rxmac && i_lwr.be[i]) rxm_r[8*i +: 8] <= i_lwr.data[8*i +: 8];
    end
    if (i_area_wr.payload) o_pay <= i_lwr.data;
    if (i_area_wr.txbuf) o_txb <= i_lwr.data;
    if (i_area_wr.txbuf) o_txb_addr <= i_laddr;
  end
endmodule : arb_area_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench of the CPU register bridge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 1'b0, i_net_clk = 1'b0, i_nrst = 1'b0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [14:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [31:0] i_s_axi_wdata = '0;
  logic [3:0] i_s_axi_wstrb = '0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata, o_core_reset, o_core_cmd, pay, txb;
  logic [12:0] o_laddr, txa;
  arb_pkg::arb_area_wr_t o_area_wr;
  arb_pkg::arb_lwr_t o_lwr;
  arb_pkg::arb_rd_src_t i_rd_src;
  int errors = 0, num_checks = 0, cyc = 0;
  // The link clock is offset so its edges never line up with ours.
  always #20 i_sys_clk = ~i_sys_clk;
  initial begin
    #13;
    forever #40 i_net_clk = ~i_net_clk;
  end
  arb_cpu_register_access_top i_arb_cpu_register_access_top (
    .i_sys_clk, .i_nrst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
    .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid,
    .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready,
    .o_s_axi_rdata, .o_s_axi_rresp, .i_net_clk, .o_area_wr, .o_laddr, .o_lwr,
    .o_core_reset, .o_core_cmd, .i_rd_src);
  arb_area_model i_arb_area_model (.i_net_clk, .i_area_wr(o_area_wr),
    .i_laddr(o_laddr), .i_lwr(o_lwr), .o_rd_src(i_rd_src), .o_pay(pay),
    .o_txb(txb), .o_txb_addr(txa));
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("unexpected timeout");
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bus tasks start at a falling edge; ready is read before the rising one.
  task automatic axi_wr(input logic [14:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ra, rw;
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_wstrb} = {a, d, s};
    {i_s_axi_awvalid, i_s_axi_wvalid} = 2'h3;
    while (i_s_axi_awvalid || i_s_axi_wvalid) begin
      {ra, rw} = {o_s_axi_awready, o_s_axi_wready};
      @(negedge i_sys_clk);
      if (ra) i_s_axi_awvalid = 1'b0;
      if (rw) i_s_axi_wvalid = 1'b0;
    end
    while (!o_s_axi_bvalid) @(negedge i_sys_clk);
    chk("bresp", 32'h0, {30'h0, o_s_axi_bresp});
    @(negedge i_sys_clk);
    i_s_axi_bready = 1'b1;
    @(negedge i_sys_clk);
    i_s_axi_bready = 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [14:0] a, input logic [31:0] e, input string nm);
    logic ra;
    i_s_axi_araddr = a;
    i_s_axi_arvalid = 1'b1;
    while (i_s_axi_arvalid) begin
      ra = o_s_axi_arready;
      @(negedge i_sys_clk);
      if (ra) i_s_axi_arvalid = 1'b0;
    end
    while (!o_s_axi_rvalid) @(negedge i_sys_clk);
    chk(nm, e, o_s_axi_rdata);
    chk("rresp", 32'h0, {30'h0, o_s_axi_rresp});
    repeat (2) @(negedge i_sys_clk);
    i_s_axi_rready = 1'b1;
    @(negedge i_sys_clk);
    i_s_axi_rready = 1'b0;
  endtask : axi_rd
  task automatic t_core();
    axi_wr(15'h0000, 32'h1234_5678, 4'hf);
    axi_wr(15'h0004, 32'haabb_ccdd, 4'hf);
    axi_wr(15'h0004, 32'h1122_3344, 4'h5);
    chk("core_reset", 32'h1234_5678, o_core_reset);
    chk("core_cmd", 32'haa22_cc44, o_core_cmd);
    axi_rd(15'h0004, 32'haa22_cc44, "cmd read");
    axi_rd(15'h0080, 32'hc0e0_0020, "core area");
    $display("test core done");
  endtask : t_core
  task automatic t_macs();
    axi_wr(15'h2004, 32'hdead_beef, 4'hf);
    axi_rd(15'h2004, 32'hdead_beef, "txmac");
    axi_wr(15'h5ffc, 32'h0bad_f00d, 4'h3);
    axi_rd(15'h5ffc, 32'h0000_f00d, "rxmac");
    axi_rd(15'h6010, 32'h5a7a_1804, "status");
    $display("test macs done");
  endtask : t_macs
  task automatic t_windows();
    axi_wr(15'h1000, 32'h600d_cafe, 4'hf);
    chk("payload", 32'h600d_cafe, pay);
    axi_wr(15'h3ffc, 32'h7777_0001, 4'hf);
    chk("txbuf addr", 32'h0fff, {19'h0, txa});
    chk("txbuf word", 32'h7777_0001, txb);
    axi_rd(15'h3ffc, 32'h0, "txbuf read");
    axi_wr(15'h4010, 32'hffff_ffff, 4'hf);
    chk("payload kept", 32'h600d_cafe, pay);
    axi_rd(15'h4010, 32'hb0f0_1004, "rxbuf");
    axi_rd(15'h7000, 32'h0, "unmapped");
    fork
      axi_wr(15'h2008, 32'h0000_1111, 4'hf);
      axi_rd(15'h2008, 32'h0000_1111, "write first");
    join
    $display("test windows done");
  endtask : t_windows
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    t_core();
    t_macs();
    t_windows();
    end_of_test();
  end
endmodule : tb_top
bind arb_cpu_register_access_top arb_bridge_chk i_arb_bridge_chk (
  .i_sys_clk, .i_net_clk, .i_nrst, .i_s_axi_bready, .i_s_axi_rready,
  .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid, .o_s_axi_bresp,
  .o_s_axi_arready, .o_s_axi_rvalid, .o_s_axi_rdata, .o_s_axi_rresp,
  .o_area_wr);
`default_nettype wire
